// >>> rtl/bip_pkg.sv
// constants shared by the interrupt prioritiser modules
package bip_pkg;
	localparam int NUM_SRC = 10;
	localparam int NUM_EXT = 4;
	localparam int LEVEL_W = 3;
	localparam int PRIO_W = 2;
	localparam int VEC_W = 8;
	localparam int ADDR_W = 32;
	localparam int IDX_W = 4;
	// source indices
	localparam logic [IDX_W-1:0] SRC_EXT_PCI_SLOT = 4'h0;
	localparam logic [IDX_W-1:0] SRC_EXT_LINE3 = 4'h1;
	localparam logic [IDX_W-1:0] SRC_EXT_PCI_BRIDGE = 4'h2;
	localparam logic [IDX_W-1:0] SRC_EXT_ABORT = 4'h3;
	localparam logic [IDX_W-1:0] SRC_TIMER_ZERO = 4'h4;
	localparam logic [IDX_W-1:0] SRC_TIMER_ONE = 4'h5;
	localparam logic [IDX_W-1:0] SRC_WATCHDOG = 4'h6;
	localparam logic [IDX_W-1:0] SRC_SERIAL_ZERO = 4'h7;
	localparam logic [IDX_W-1:0] SRC_SERIAL_ONE = 4'h8;
	localparam logic [IDX_W-1:0] SRC_TWO_WIRE = 4'h9;
	// levels
	localparam logic [LEVEL_W-1:0] LEVEL_NMI = 3'h7;
	localparam logic [LEVEL_W-1:0] LEVEL_NONE = 3'h0;
	// external line level sets, entry i at [3i+:3]
	localparam logic [NUM_EXT*LEVEL_W-1:0] EXT_LEVELS_ODD = 12'hf59;
	localparam logic [NUM_EXT*LEVEL_W-1:0] EXT_LEVELS_EVEN = 12'hfa2;
	// reset defaults per source, entry i at [w*i+:w]
	localparam logic [NUM_SRC*LEVEL_W-1:0] DEF_LEVEL =
		{3'h3, 3'h3, 3'h3, 3'h7, 3'h5, 3'h5, 3'h7, 3'h5, 3'h3, 3'h1};
	localparam logic [NUM_SRC*PRIO_W-1:0] DEF_PRIO =
		{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h1, 2'h3, 2'h3};
	localparam logic [NUM_SRC-1:0] DEF_AUTO = 10'h3bf;
	localparam logic [VEC_W-1:0] VEC_UNINIT = 8'h0f;
	localparam logic [VEC_W-1:0] AUTOVEC_BASE = 8'h18;
	localparam logic [VEC_W-1:0] VEC_SPURIOUS = 8'h18;
	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int VEC_WAIT_NS = 128;
	localparam int VEC_WAIT_CYC = (VEC_WAIT_NS / CLK_PERIOD_NS < 1) ? 1 :
		VEC_WAIT_NS / CLK_PERIOD_NS;
	typedef enum logic [2:0] {
		BIP_IDLE,
		BIP_WAIT_END,
		BIP_WAIT_VEC,
		BIP_DONE
	} bip_state_t;
endpackage

// >>> rtl/bip_cfg.sv
// per-source level, priority, autovector and vector settings
module bip_cfg
	import bip_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// configuration write
	input wire logic level_set_even,
	input wire logic cfg_write,
	input wire logic [bip_pkg::IDX_W-1:0] cfg_index,
	input wire logic [bip_pkg::LEVEL_W-1:0] cfg_level,
	input wire logic [bip_pkg::PRIO_W-1:0] cfg_prio,
	input wire logic cfg_autovec,
	input wire logic [bip_pkg::VEC_W-1:0] cfg_vector,
	// settings out
	output logic [bip_pkg::NUM_SRC*bip_pkg::LEVEL_W-1:0] src_level,
	output logic [bip_pkg::NUM_SRC*bip_pkg::PRIO_W-1:0] src_prio,
	output logic [bip_pkg::NUM_SRC-1:0] src_auto,
	output logic [bip_pkg::NUM_SRC*bip_pkg::VEC_W-1:0] src_vec
);
	import bip_pkg::*;

	genvar i;
	generate
		for (i = 0; i < NUM_SRC; i++) begin : g_src
			logic hit;
			assign hit = cfg_write && (cfg_index == IDX_W'(i));
			if (i < NUM_EXT) begin : g_ext
				// pin levels follow the chosen set only [RQ6]
				assign src_level[i*LEVEL_W +: LEVEL_W] = level_set_even ?
					EXT_LEVELS_EVEN[i*LEVEL_W +: LEVEL_W] :
					EXT_LEVELS_ODD[i*LEVEL_W +: LEVEL_W];
			end else begin : g_int
				logic [LEVEL_W-1:0] lvl;
				// any level for internal sources [RQ8]
				always_ff @(posedge core_clk) begin
					if (rst)
						lvl <= DEF_LEVEL[i*LEVEL_W +: LEVEL_W]; // [RQ10] [RQ11]
					else if (hit)
						lvl <= cfg_level;
				end
				assign src_level[i*LEVEL_W +: LEVEL_W] = lvl;
			end
			always_ff @(posedge core_clk) begin
				if (rst) begin
					src_prio[i*PRIO_W +: PRIO_W] <=
						DEF_PRIO[i*PRIO_W +: PRIO_W]; // [RQ12] [RQ13] [RQ14]
					src_auto[i] <= DEF_AUTO[i]; // [RQ11] [RQ12] [RQ13]
					src_vec[i*VEC_W +: VEC_W] <= VEC_UNINIT; // [RQ10]
				end else if (hit) begin
					src_prio[i*PRIO_W +: PRIO_W] <= cfg_prio; // [RQ8]
					// abort switch can never answer with a vector
					src_auto[i] <= cfg_autovec ||
						(i == int'(SRC_EXT_ABORT)); // [RQ14]
					src_vec[i*VEC_W +: VEC_W] <= cfg_vector;
				end
			end
		end
	endgenerate
endmodule

// >>> rtl/bip_pick.sv
// picks the most urgent pending source
module bip_pick
	import bip_pkg::*;
(
	// requests and settings
	input wire logic [bip_pkg::NUM_SRC-1:0] req,
	input wire logic [bip_pkg::NUM_SRC*bip_pkg::LEVEL_W-1:0] src_level,
	input wire logic [bip_pkg::NUM_SRC*bip_pkg::PRIO_W-1:0] src_prio,
	// winner
	output logic found,
	output logic [bip_pkg::IDX_W-1:0] win_idx,
	output logic [bip_pkg::LEVEL_W-1:0] win_level
);
	import bip_pkg::*;

	logic [LEVEL_W+PRIO_W-1:0] best_key;
	logic [LEVEL_W+PRIO_W-1:0] key;

	// level first, relative priority breaks ties [RQ16] [RQ8]
	always_comb begin
		found = 1'b0;
		win_idx = '0;
		best_key = '0;
		key = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			key = {src_level[i*LEVEL_W +: LEVEL_W],
				src_prio[i*PRIO_W +: PRIO_W]};
			// level zero means the source is switched off
			if (req[i] && key[LEVEL_W+PRIO_W-1 -: LEVEL_W] != LEVEL_NONE &&
				(!found || key > best_key)) begin
				found = 1'b1;
				best_key = key;
				win_idx = IDX_W'(i);
			end
		end
		win_level = best_key[LEVEL_W+PRIO_W-1 -: LEVEL_W];
	end
endmodule

// >>> rtl/bip_top.sv
// interrupt prioritiser and acknowledge sequencer
// How it works
// (RQ1) seven request levels; a larger number is more urgent.
// (RQ2) level above status mask starts acknowledge when the instruction ends.
// (RQ3) a vectored source answers the acknowledge with its vector number.
// (RQ4) autovector sources use a fixed table entry picked by level.
// (RQ5) handler table base comes from the movable vector base pointer.
// (RQ6) external lines take levels 1,3,5,7 or 2,4,6,7; default first set.
// (RQ7) six internal requests: two timers, watchdog, two serial, two-wire.
// (RQ8) any internal source any level; ties ordered by relative priority 0 to 3.
// (RQ9) software never gives two sources equal level and priority.
// (RQ10) watchdog defaults to level 7, priority 2, uninitialised vector.
// (RQ11) serial zero level 3 prio 2, serial one level 3 prio 1, autovector.
// (RQ12) two-wire module defaults to level 3, priority 0, autovector.
// (RQ13) timers level 5 autovector; timer zero prio 3, timer one prio 2.
// (RQ14) abort line is non-maskable level 7, priority 3, autovector.
// (RQ15) pci slot drives level-one line, pci bridge the level-five line.
// (RQ16) highest level wins, then highest relative priority.
// (RQ17) handler address is vector base plus four times the vector.
module bip_top
	import bip_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// external request lines, active low
	input wire logic pci_slot_request_line_n,
	input wire logic ext_level3_request_line_n,
	input wire logic pci_bridge_request_line_n,
	input wire logic abort_request_line_n,
	// internal requests
	input wire logic timer_zero_req,
	input wire logic timer_one_req,
	input wire logic watchdog_req,
	input wire logic serial_port_zero_req,
	input wire logic serial_port_one_req,
	input wire logic two_wire_module_req,
	// configuration
	input wire logic level_set_even,
	input wire logic cfg_write,
	input wire logic [bip_pkg::IDX_W-1:0] cfg_index,
	input wire logic [bip_pkg::LEVEL_W-1:0] cfg_level,
	input wire logic [bip_pkg::PRIO_W-1:0] cfg_prio,
	input wire logic cfg_autovec,
	input wire logic [bip_pkg::VEC_W-1:0] cfg_vector,
	// processor core
	input wire logic [bip_pkg::LEVEL_W-1:0] status_word_mask,
	input wire logic instr_done,
	input wire logic [bip_pkg::ADDR_W-1:0] vector_base_pointer,
	output logic irq_pending,
	output logic [bip_pkg::LEVEL_W-1:0] irq_level,
	// acknowledge cycle
	output logic iack_start,
	output logic [bip_pkg::LEVEL_W-1:0] iack_level,
	output logic [bip_pkg::IDX_W-1:0] iack_source,
	input wire logic ack_vector_valid,
	input wire logic [bip_pkg::VEC_W-1:0] ack_vector,
	// handler fetch
	output logic handler_valid,
	output logic [bip_pkg::VEC_W-1:0] handler_vector,
	output logic [bip_pkg::ADDR_W-1:0] handler_addr,
	output logic handler_spurious
);
	import bip_pkg::*;

	logic [NUM_SRC-1:0] req;
	logic [NUM_SRC*LEVEL_W-1:0] src_level;
	logic [NUM_SRC*PRIO_W-1:0] src_prio;
	logic [NUM_SRC-1:0] src_auto;
	logic [NUM_SRC*VEC_W-1:0] src_vec;
	logic pick_found;
	logic [IDX_W-1:0] pick_idx;
	logic [LEVEL_W-1:0] pick_level;
	logic take;
	bip_state_t state;
	bip_state_t next_state;
	logic ack_auto;
	logic [VEC_W-1:0] ack_vec;
	logic ack_spur;
	logic [$clog2(VEC_WAIT_CYC+1)-1:0] wait_cnt;
	logic wait_over;

	// four pins then six internal sources [RQ7] [RQ15]
	assign req = {two_wire_module_req, serial_port_one_req,
		serial_port_zero_req, watchdog_req, timer_one_req, timer_zero_req,
		~abort_request_line_n, ~pci_bridge_request_line_n,
		~ext_level3_request_line_n, ~pci_slot_request_line_n};

	bip_cfg u_cfg (
		.core_clk(core_clk),
		.rst(rst),
		.level_set_even(level_set_even),
		.cfg_write(cfg_write),
		.cfg_index(cfg_index),
		.cfg_level(cfg_level),
		.cfg_prio(cfg_prio),
		.cfg_autovec(cfg_autovec),
		.cfg_vector(cfg_vector),
		.src_level(src_level),
		.src_prio(src_prio),
		.src_auto(src_auto),
		.src_vec(src_vec)
	);

	bip_pick u_pick (
		.req(req),
		.src_level(src_level),
		.src_prio(src_prio),
		.found(pick_found),
		.win_idx(pick_idx),
		.win_level(pick_level)
	);

	// level 7 passes any mask, the rest must beat it [RQ1] [RQ2] [RQ14]
	assign take = pick_found &&
		(pick_level > status_word_mask || pick_level == LEVEL_NMI);
	assign wait_over = (wait_cnt == ($bits(wait_cnt))'(VEC_WAIT_CYC - 1));

	always_comb begin
		next_state = state;
		case (state)
			BIP_IDLE:
				if (take)
					next_state = BIP_WAIT_END;
			BIP_WAIT_END:
				// request may drop before the instruction ends
				if (!take)
					next_state = BIP_IDLE;
				else if (instr_done) begin // [RQ2]
					// external vectored sources answer on the bus [RQ3]
					if (src_auto[pick_idx] || pick_idx >= IDX_W'(NUM_EXT))
						next_state = BIP_DONE;
					else
						next_state = BIP_WAIT_VEC;
				end
			BIP_WAIT_VEC:
				if (ack_vector_valid || wait_over)
					next_state = BIP_DONE;
			BIP_DONE:
				next_state = BIP_IDLE;
			default:
				next_state = BIP_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			state <= BIP_IDLE;
		else
			state <= next_state;
	end

	// pending status for the core
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_pending <= 1'b0;
			irq_level <= LEVEL_NONE;
		end else begin
			irq_pending <= take;
			irq_level <= pick_found ? pick_level : LEVEL_NONE;
		end
	end

	// acknowledge latch; vector chosen here so the fetch is one add
	always_ff @(posedge core_clk) begin
		if (rst) begin
			iack_start <= 1'b0;
			iack_level <= LEVEL_NONE;
			iack_source <= '0;
			ack_auto <= 1'b0;
			ack_vec <= '0;
			ack_spur <= 1'b0;
		end else begin
			iack_start <= 1'b0;
			if (state == BIP_WAIT_END && take && instr_done) begin
				iack_start <= 1'b1;
				iack_level <= pick_level;
				iack_source <= pick_idx;
				ack_auto <= src_auto[pick_idx];
				ack_spur <= 1'b0;
				if (src_auto[pick_idx])
					ack_vec <= AUTOVEC_BASE + VEC_W'(pick_level); // [RQ4]
				else
					ack_vec <= src_vec[pick_idx*VEC_W +: VEC_W];
			end else if (state == BIP_WAIT_VEC) begin
				if (ack_vector_valid)
					ack_vec <= ack_vector; // [RQ3]
				else if (wait_over) begin
					// silent source: fall back rather than hang the core
					ack_vec <= VEC_SPURIOUS;
					ack_spur <= 1'b1;
				end
			end
		end
	end

	// parks at its limit so the timeout holds until the state moves
	always_ff @(posedge core_clk) begin
		if (rst || state != BIP_WAIT_VEC)
			wait_cnt <= '0;
		else if (!wait_over)
			wait_cnt <= wait_cnt + 1'b1;
	end

	// handler fetch address, base sampled at fetch time [RQ5] [RQ17]
	always_ff @(posedge core_clk) begin
		if (rst) begin
			handler_valid <= 1'b0;
			handler_vector <= '0;
			handler_addr <= '0;
			handler_spurious <= 1'b0;
		end else begin
			handler_valid <= (state == BIP_DONE);
			if (state == BIP_DONE) begin
				handler_vector <= ack_vec;
				handler_addr <= vector_base_pointer +
					{(ADDR_W-VEC_W-2)'(0), ack_vec, 2'b00};
				handler_spurious <= ack_spur;
			end
		end
	end

	// checks
	logic pick_is_best;
	always_comb begin
		pick_is_best = 1'b1;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (req[i] && src_level[i*LEVEL_W +: LEVEL_W] != LEVEL_NONE &&
				{src_level[i*LEVEL_W +: LEVEL_W],
				src_prio[i*PRIO_W +: PRIO_W]} >
				{pick_level, src_prio[pick_idx*PRIO_W +: PRIO_W]})
				pick_is_best = 1'b0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_PICK_BEST: assert property (pick_found |-> pick_is_best) // [RQ16]
		else $error("picked source is not the most urgent");
	AST_MASKED: assert property (state == BIP_IDLE && pick_found && // [RQ2]
		pick_level <= status_word_mask && pick_level != LEVEL_NMI
		|=> state == BIP_IDLE)
		else $error("masked request was taken");
	AST_NMI: assert property (state == BIP_IDLE && // [RQ14]
		pick_level == LEVEL_NMI && pick_found |=> state == BIP_WAIT_END)
		else $error("level 7 request was masked");
	AST_WAIT_INSTR: assert property ($rose(iack_start) |-> // [RQ2]
		$past(instr_done) && $past(state) == BIP_WAIT_END)
		else $error("acknowledge before instruction end");
	AST_AUTOVEC: assert property (iack_start && ack_auto |=> // [RQ4]
		handler_valid && handler_vector == AUTOVEC_BASE +
		VEC_W'($past(iack_level)))
		else $error("autovector number wrong or late");
	AST_VECTORED: assert property (state == BIP_WAIT_VEC && // [RQ3]
		ack_vector_valid |-> ##2 handler_valid &&
		handler_vector == $past(ack_vector, 2))
		else $error("supplied vector not used");
	AST_ADDR: assert property (handler_valid |-> // [RQ5]
		handler_addr == $past(vector_base_pointer) +
		{(ADDR_W-VEC_W-2)'(0), handler_vector, 2'b00}) // [RQ17]
		else $error("handler address not base plus four times vector");
	AST_EXT_LEVELS: assert property (src_level[3*SRC_EXT_ABORT +: 3] == // [RQ6]
		LEVEL_NMI && src_level[2:0] == (level_set_even ? 3'h2 : 3'h1))
		else $error("external line level set wrong");
	AST_DEF_TIMERS: assert property ($fell(rst) |-> // [RQ13]
		src_level[3*SRC_TIMER_ZERO +: 3] == 3'h5 &&
		src_prio[2*SRC_TIMER_ZERO +: 2] == 2'h3 &&
		src_prio[2*SRC_TIMER_ONE +: 2] == 2'h2 && src_auto[5:4] == 2'h3)
		else $error("timer defaults wrong");
	AST_DEF_SERIAL: assert property ($fell(rst) |-> // [RQ11]
		src_prio[2*SRC_SERIAL_ZERO +: 2] == 2'h2 &&
		src_prio[2*SRC_TWO_WIRE +: 2] == 2'h0 && // [RQ12]
		src_level[3*SRC_TWO_WIRE +: 3] == 3'h3 && src_auto[9:7] == 3'h7)
		else $error("serial or two-wire defaults wrong");
	AST_DEF_WDOG: assert property ($fell(rst) |-> // [RQ10]
		src_level[3*SRC_WATCHDOG +: 3] == LEVEL_NMI &&
		src_prio[2*SRC_WATCHDOG +: 2] == 2'h2 && !src_auto[SRC_WATCHDOG])
		else $error("watchdog defaults wrong");
	AST_TIMEOUT: assert property (state == BIP_WAIT_VEC && !ack_vector_valid
		|-> ##[0:16] state != BIP_WAIT_VEC)
		else $error("vector wait not bounded");
	AST_SPURIOUS: assert property (state == BIP_WAIT_VEC && // [RQ3]
		wait_over && !ack_vector_valid |-> ##2 handler_valid &&
		handler_spurious && handler_vector == VEC_SPURIOUS)
		else $error("silent source not flagged spurious");
	AST_IACK_PULSE: assert property (iack_start |=> !iack_start) // [RQ2]
		else $error("acknowledge start longer than one cycle");
	AST_HANDLER_PULSE: assert property (handler_valid |=> // [RQ5]
		!handler_valid)
		else $error("handler valid longer than one cycle");
	AST_IRQ_LEVEL: assert property (pick_found |=> // [RQ1]
		irq_level == $past(pick_level))
		else $error("pending level not reported");
	AST_ABORT_AUTO: assert property (src_auto[SRC_EXT_ABORT]) // [RQ14]
		else $error("abort source left without autovector");

	COV_AUTO: cover property (iack_start && ack_auto ##1 handler_valid);
	COV_DROP: cover property (state == BIP_WAIT_END && !take ##1
		state == BIP_IDLE);
	COV_VECTORED: cover property (state == BIP_WAIT_VEC && ack_vector_valid);
	COV_SPURIOUS: cover property (handler_valid && handler_spurious);
	COV_NMI: cover property (iack_start && iack_level == LEVEL_NMI);
endmodule

// >>> tb/bip_core_model.sv
// processor core and vectoring source model facing the prioritiser
module bip_core_model
	import bip_pkg::*;
#(
	parameter int ANS_DELAY = 3
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// bench controls
	input wire logic hold_instr,
	input wire logic ans_en,
	input wire logic [bip_pkg::VEC_W-1:0] ans_vec,
	// prioritiser side
	input wire logic irq_pending,
	input wire logic iack_start,
	output logic instr_done,
	output logic ack_vector_valid,
	output logic [bip_pkg::VEC_W-1:0] ack_vector
);
	timeunit 1ns;
	timeprecision 1ps;
	import bip_pkg::*;

	int wait_cnt;
	// instruction ends while a request is flagged, unless held
	always_ff @(negedge core_clk) begin
		if (rst) begin
			instr_done <= 1'b0;
		end else begin
			instr_done <= irq_pending && !hold_instr && !instr_done;
		end
	end
	// vector answer a few cycles into the acknowledge
	// idle bus toggles while answers are enabled, so a stale vector never looks valid
	always_ff @(negedge core_clk) begin
		if (rst || !ans_en) begin
			wait_cnt <= 0;
			ack_vector_valid <= 1'b0;
			ack_vector <= 8'ha5;
		end else if (wait_cnt == 1 && !iack_start) begin
			wait_cnt <= 0;
			ack_vector_valid <= 1'b1;
			ack_vector <= ans_vec;
		end else begin
			ack_vector_valid <= 1'b0;
			ack_vector <= ~ack_vector;
			if (iack_start)
				wait_cnt <= ANS_DELAY;
			else if (wait_cnt > 1)
				wait_cnt <= wait_cnt - 1;
		end
	end
endmodule

// >>> tb/bip_top_tb.sv
// self-checking bench for the interrupt prioritiser
`define CHK(got, exp) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module bip_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import bip_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] ext_n = 4'hf;
	logic [5:0] int_req = 6'h00;
	logic level_set_even = 1'b0;
	logic cfg_write = 1'b0;
	logic [IDX_W-1:0] cfg_index = 4'h0;
	logic [LEVEL_W-1:0] cfg_level = 3'h0;
	logic [PRIO_W-1:0] cfg_prio = 2'h0;
	logic cfg_autovec = 1'b0;
	logic [VEC_W-1:0] cfg_vector = 8'h00;
	logic [LEVEL_W-1:0] mask = 3'h0;
	logic [ADDR_W-1:0] table_base = 32'h0010_0000;
	logic hold_instr = 1'b0;
	logic ans_en = 1'b0;
	logic [VEC_W-1:0] ans_vec = 8'h40;
	logic instr_done, ack_vector_valid, irq_pending, iack_start;
	logic handler_valid, handler_spurious;
	logic [VEC_W-1:0] ack_vector, handler_vector;
	logic [LEVEL_W-1:0] irq_level, iack_level;
	logic [IDX_W-1:0] iack_source;
	logic [ADDR_W-1:0] handler_addr;
	int bad_count = 0;
	int comparisons = 0;
	int iacks = 0;
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (iack_start === 1'b1)
			iacks++;
	end
	bip_top i_bip_top (.core_clk(core_clk), .rst(rst),
		.pci_slot_request_line_n(ext_n[0]),
		.ext_level3_request_line_n(ext_n[1]),
		.pci_bridge_request_line_n(ext_n[2]),
		.abort_request_line_n(ext_n[3]),
		.timer_zero_req(int_req[0]), .timer_one_req(int_req[1]),
		.watchdog_req(int_req[2]), .serial_port_zero_req(int_req[3]),
		.serial_port_one_req(int_req[4]), .two_wire_module_req(int_req[5]),
		.level_set_even(level_set_even), .cfg_write(cfg_write),
		.cfg_index(cfg_index), .cfg_level(cfg_level), .cfg_prio(cfg_prio),
		.cfg_autovec(cfg_autovec), .cfg_vector(cfg_vector),
		.status_word_mask(mask), .instr_done(instr_done),
		.vector_base_pointer(table_base), .irq_pending(irq_pending),
		.irq_level(irq_level), .iack_start(iack_start),
		.iack_level(iack_level), .iack_source(iack_source),
		.ack_vector_valid(ack_vector_valid), .ack_vector(ack_vector),
		.handler_valid(handler_valid), .handler_vector(handler_vector),
		.handler_addr(handler_addr), .handler_spurious(handler_spurious));
	bip_core_model i_bip_core_model (.core_clk(core_clk), .rst(rst),
		.hold_instr(hold_instr), .ans_en(ans_en), .ans_vec(ans_vec),
		.irq_pending(irq_pending), .iack_start(iack_start),
		.instr_done(instr_done), .ack_vector_valid(ack_vector_valid),
		.ack_vector(ack_vector));
	// called at a falling edge only, so no extra edge slips by
	task automatic drive(input logic [3:0] en, input logic [5:0] ir);
		ext_n = en;
		int_req = ir;
	endtask
	task automatic cfg(input logic [3:0] idx, input logic [2:0] lv,
		input logic [1:0] pr, input logic av, input logic [7:0] vec);
		@(negedge core_clk);
		cfg_write = 1'b1;
		cfg_index = idx;
		cfg_level = lv;
		cfg_prio = pr;
		cfg_autovec = av;
		cfg_vector = vec;
		@(negedge core_clk);
		cfg_write = 1'b0;
	endtask
	task automatic take(input logic [2:0] lv, input logic [3:0] src,
		input logic [7:0] vec, input logic spur);
		int n0;
		n0 = iacks;
		repeat (60) begin
			@(negedge core_clk);
			if (handler_valid === 1'b1)
				break;
		end
		`CHK(handler_valid, 1'b1)
		`CHK(iacks, n0 + 1)
		`CHK(iack_level, lv)
		`CHK(iack_source, src)
		`CHK(handler_vector, vec)
		`CHK(handler_spurious, spur)
		`CHK(handler_addr, table_base + {22'h0, vec, 2'b00})
	endtask
	task automatic t_defaults();
		drive(4'hf, 6'h03);
		take(3'h5, SRC_TIMER_ZERO, AUTOVEC_BASE + 8'h5, 1'b0);
		drive(4'hf, 6'h02);
		take(3'h5, SRC_TIMER_ONE, AUTOVEC_BASE + 8'h5, 1'b0);
		drive(4'hf, 6'h38);
		take(3'h3, SRC_SERIAL_ZERO, AUTOVEC_BASE + 8'h3, 1'b0);
		drive(4'hf, 6'h30);
		take(3'h3, SRC_SERIAL_ONE, AUTOVEC_BASE + 8'h3, 1'b0);
		drive(4'hf, 6'h20);
		take(3'h3, SRC_TWO_WIRE, AUTOVEC_BASE + 8'h3, 1'b0);
		drive(4'hf, 6'h00);
	endtask
	task automatic t_seven();
		// abort ignores a request for vectored mode
		cfg(SRC_EXT_ABORT, 3'h7, 2'h3, 1'b0, 8'h66);
		mask = 3'h7;
		table_base = 32'h0000_0000;
		drive(4'h7, 6'h04);
		take(3'h7, SRC_EXT_ABORT, AUTOVEC_BASE + 8'h7, 1'b0);
		drive(4'hf, 6'h04);
		take(3'h7, SRC_WATCHDOG, VEC_UNINIT, 1'b0);
		drive(4'hf, 6'h00);
		mask = 3'h0;
	endtask
	task automatic t_mask();
		int n0;
		n0 = iacks;
		mask = 3'h5;
		drive(4'hf, 6'h01);
		repeat (8) @(negedge core_clk);
		`CHK(irq_pending, 1'b0)
		`CHK(irq_level, 3'h5)
		`CHK(iacks, n0)
		mask = 3'h4;
		take(3'h5, SRC_TIMER_ZERO, AUTOVEC_BASE + 8'h5, 1'b0);
		drive(4'hf, 6'h00);
		mask = 3'h0;
	endtask
	// request withdrawn before the instruction ends: no acknowledge
	task automatic t_drop();
		int n0;
		n0 = iacks;
		hold_instr <= 1'b1;
		drive(4'hf, 6'h02);
		repeat (4) @(negedge core_clk);
		`CHK(irq_pending, 1'b1)
		drive(4'hf, 6'h00);
		repeat (3) @(negedge core_clk);
		hold_instr <= 1'b0;
		repeat (6) @(negedge core_clk);
		`CHK(iacks, n0)
	endtask
	task automatic t_ext();
		cfg(SRC_EXT_PCI_BRIDGE, 3'h5, 2'h1, 1'b0, 8'h00);
		ans_en <= 1'b1;
		drive(4'hb, 6'h00);
		take(3'h5, SRC_EXT_PCI_BRIDGE, 8'h40, 1'b0);
		ans_en <= 1'b0;
		take(3'h5, SRC_EXT_PCI_BRIDGE, VEC_SPURIOUS, 1'b1);
		drive(4'hf, 6'h00);
		cfg(SRC_EXT_PCI_BRIDGE, 3'h5, 2'h1, 1'b1, 8'h00);
		level_set_even = 1'b1;
		drive(4'he, 6'h00);
		take(3'h2, SRC_EXT_PCI_SLOT, AUTOVEC_BASE + 8'h2, 1'b0);
		level_set_even = 1'b0;
		take(3'h1, SRC_EXT_PCI_SLOT, AUTOVEC_BASE + 8'h1, 1'b0);
		drive(4'hf, 6'h00);
	endtask
	// pairs stay unique so the pick is well defined
	task automatic t_cfg();
		int n0;
		cfg(SRC_TIMER_ONE, 3'h6, 2'h0, 1'b1, 8'h00);
		cfg(SRC_TWO_WIRE, 3'h4, 2'h3, 1'b0, 8'h55);
		drive(4'hf, 6'h23);
		take(3'h6, SRC_TIMER_ONE, AUTOVEC_BASE + 8'h6, 1'b0);
		drive(4'hf, 6'h21);
		take(3'h5, SRC_TIMER_ZERO, AUTOVEC_BASE + 8'h5, 1'b0);
		drive(4'hf, 6'h20);
		take(3'h4, SRC_TWO_WIRE, 8'h55, 1'b0);
		drive(4'hf, 6'h00);
		// level zero switches a source off
		cfg(SRC_TIMER_ZERO, 3'h0, 2'h3, 1'b1, 8'h00);
		n0 = iacks;
		drive(4'hf, 6'h01);
		repeat (8) @(negedge core_clk);
		`CHK(irq_pending, 1'b0)
		`CHK(irq_level, LEVEL_NONE)
		`CHK(iacks, n0)
		drive(4'hf, 6'h00);
	endtask
	task automatic results();
		if (bad_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// whole run needs under two hundred cycles
	initial begin
		#20us;
		bad_count++;
		results();
	end
	initial begin
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		@(negedge core_clk);
		t_defaults();
		t_seven();
		t_mask();
		t_drop();
		t_ext();
		t_cfg();
		results();
	end
endmodule
